// file: design/icl_cmd_alarm_status.v
// Command execution, offsets, dual alarm and status logic behind the serial port
`timescale 1ns/1ps
`include "icl_cmd_regs.vh"
module icl_cmd_alarm_status #(
    parameter FLASH_CYCLES = `ICL_FLASH_CYCLES,
    parameter POR_CYCLES   = `ICL_POR_CYCLES
) (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    // Serial port, mode 3
    input  wire        i_spi_sclk,
    input  wire        i_spi_cs_n,
    input  wire        i_spi_mosi,
    output reg         o_spi_miso,
    output wire        o_spi_miso_oe,
    // Sensor results from the signal chain
    input  wire        i_sample_valid,
    input  wire [15:0] i_x_accel_result,
    input  wire [15:0] i_y_accel_result,
    input  wire [15:0] i_x_tilt_result,
    input  wire [15:0] i_y_tilt_result,
    input  wire [15:0] i_vertical_angle_result,
    input  wire [11:0] i_supply_result,
    // Flash and supply monitors
    input  wire        i_flash_fault,
    input  wire        i_vdd_above_low,
    input  wire        i_vdd_above_high,
    // Offsets, DAC and alarm outputs
    output wire [15:0] o_x_accel_offset,
    output wire [15:0] o_y_accel_offset,
    output wire [15:0] o_x_tilt_offset,
    output wire [15:0] o_y_tilt_offset,
    output wire [15:0] o_vertical_angle_offset,
    output reg  [11:0] o_dac_level,
    output reg  [1:0]  o_alarm,
    output reg         o_alarm_pin,
    // Processor control
    output reg         o_core_restart,
    output reg         o_por_reset,
    output wire        o_busy
);
    localparam ST_IDLE  = 1'b0;
    localparam ST_FLASH = 1'b1;
    localparam [23:0] FLASH_LAST = FLASH_CYCLES[23:0] - 24'h000001;
    localparam [23:0] POR_LAST   = POR_CYCLES[23:0] - 24'h000001;

    reg  [15:0] ureg [0:`ICL_NUM_USER-1];
    reg  [15:0] nv   [0:`ICL_NUM_FLASH-1];
    reg  [7:0]  cmd_pend;
    reg         state;
    reg  [23:0] flash_cnt;
    reg  [15:0] status;
    reg         flash_fail;
    reg         clear_req;
    integer     i;

    // Two-flop synchronisers; third flop only feeds the sclk edge detector
    reg [2:0] sclk_q;
    reg [1:0] cs_q;
    reg [1:0] mosi_q;
    reg [1:0] vlo_q;
    reg [1:0] vhi_q;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q <= 3'h7;
            cs_q   <= 2'h3;
            mosi_q <= 2'h0;
            vlo_q  <= 2'h0;
            vhi_q  <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], i_spi_sclk};
            cs_q   <= {cs_q[0], i_spi_cs_n};
            mosi_q <= {mosi_q[0], i_spi_mosi};
            vlo_q  <= {vlo_q[0], i_vdd_above_low};
            vhi_q  <= {vhi_q[0], i_vdd_above_high};
        end
    end
    wire sel_n   = cs_q[1];
    wire sclk_up = sclk_q[1] & ~sclk_q[2];
    wire sclk_dn = ~sclk_q[1] & sclk_q[2];

    // Serial frame: bit 15 write, 14:8 address, 7:0 data
    reg  [15:0] rx_sh;
    reg  [3:0]  bit_cnt;
    reg  [15:0] tx_word;
    reg  [15:0] tx_sh;
    reg         frame_done;
    reg  [15:0] frame;
    reg         prev_sel_n;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_sh <= 16'h0000; bit_cnt <= 4'h0; tx_sh <= 16'h0000;
            frame_done <= 1'b0; frame <= 16'h0000; o_spi_miso <= 1'b0; prev_sel_n <= 1'b1;
        end else begin
            frame_done <= 1'b0;
            prev_sel_n <= sel_n;
            if (sel_n) begin
                bit_cnt <= 4'h0;
            end else if (prev_sel_n) begin
                tx_sh <= tx_word;
            end else begin
                if (sclk_dn) begin
                    o_spi_miso <= tx_sh[15];
                    tx_sh      <= {tx_sh[14:0], 1'b0};
                end
                if (sclk_up) begin
                    rx_sh   <= {rx_sh[14:0], mosi_q[1]};
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == 4'hf) begin
                        frame_done <= 1'b1;
                        frame      <= {rx_sh[14:0], mosi_q[1]};
                    end
                end
            end
        end
    end
    assign o_spi_miso_oe = ~sel_n;

    wire       wr_en   = frame_done & frame[15];
    wire       rd_en   = frame_done & ~frame[15];
    wire [6:0] addr    = frame[14:8];
    wire [7:0] wdata   = frame[7:0];
    wire [6:0] rel     = addr - `ICL_ADDR_USER_BASE;
    wire [3:0] idx     = rel[4:1];
    wire       in_user = (addr >= `ICL_ADDR_USER_BASE) && (addr <= `ICL_ADDR_USER_LAST);
    wire       busy    = (state != ST_IDLE) || (cmd_pend != 8'h00);
    wire       st_hit  = ({addr[6:1], 1'b0} == `ICL_ADDR_STATUS);
    wire       st_read = rd_en && st_hit;
    assign o_busy = busy;

    // Read data is returned in the following frame
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_word <= 16'h0000;
        end else if (rd_en) begin
            if (in_user)
                tx_word <= ureg[idx];
            else if (st_hit)
                tx_word <= status;
            else if ({addr[6:1], 1'b0} == `ICL_ADDR_COMMAND)
                tx_word <= {8'h00, cmd_pend};
            else
                tx_word <= 16'h0000;
        end
    end

    // Power-on window watchdog
    reg [23:0] por_cnt;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_cnt     <= 24'h000000;
            o_por_reset <= 1'b0;
        end else begin
            o_por_reset <= 1'b0;
            if (!vlo_q[1] || vhi_q[1]) begin
                por_cnt <= 24'h000000;
            end else if (por_cnt == POR_LAST) begin
                por_cnt     <= 24'h000000;
                o_por_reset <= 1'b1;
            end else begin
                por_cnt <= por_cnt + 24'h000001;
            end
        end
    end

    // Command execution and register file
    wire [15:0] sense [0:4];
    assign sense[0] = i_x_accel_result;
    assign sense[1] = i_y_accel_result;
    assign sense[2] = i_x_tilt_result;
    assign sense[3] = i_y_tilt_result;
    assign sense[4] = i_vertical_angle_result;
    wire flash_err = status[`ICL_ST_FLASH_ERR];
    wire do_reset  = cmd_pend[`ICL_CMD_SWRESET] | o_por_reset;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (i = 0; i < `ICL_NUM_USER; i = i + 1) ureg[i] <= `ICL_USER_RESET;
            for (i = 0; i < `ICL_NUM_FLASH; i = i + 1) nv[i] <= `ICL_USER_RESET;
            cmd_pend <= 8'h00; state <= ST_IDLE; flash_cnt <= 24'h000000;
            o_dac_level <= 12'h000; o_core_restart <= 1'b0;
            flash_fail <= 1'b0; clear_req <= 1'b0;
        end else begin
            o_core_restart <= 1'b0;
            flash_fail     <= 1'b0;
            clear_req      <= 1'b0;
            if (wr_en && in_user) begin
                if (addr[0]) ureg[idx][15:8] <= wdata;
                else         ureg[idx][7:0]  <= wdata;
            end
            if (wr_en && addr == `ICL_ADDR_COMMAND && !busy)
                cmd_pend <= wdata & `ICL_CMD_MASK;
            if (do_reset) begin
                for (i = 0; i < `ICL_NUM_FLASH; i = i + 1) ureg[i] <= nv[i];
                ureg[`ICL_IDX_AUX_DAC] <= `ICL_USER_RESET;
                o_core_restart <= 1'b1;
                cmd_pend <= 8'h00;
                state    <= ST_IDLE;
            end else if (state == ST_FLASH) begin
                if (flash_cnt == FLASH_LAST) begin
                    if (i_flash_fault)
                        flash_fail <= 1'b1;
                    else
                        for (i = 0; i < `ICL_NUM_FLASH; i = i + 1) nv[i] <= ureg[i];
                    cmd_pend[`ICL_CMD_FLASH] <= 1'b0;
                    state <= ST_IDLE;
                end else begin
                    flash_cnt <= flash_cnt + 24'h000001;
                end
            end else if (cmd_pend[`ICL_CMD_CLEAR]) begin
                clear_req <= 1'b1;
                cmd_pend[`ICL_CMD_CLEAR] <= 1'b0;
            end else if (cmd_pend[`ICL_CMD_FACTORY]) begin
                for (i = 0; i < 5; i = i + 1) ureg[i] <= `ICL_OFFSET_DEFAULT;
                cmd_pend[`ICL_CMD_FACTORY] <= 1'b0;
            end else if (cmd_pend[`ICL_CMD_AUTONULL]) begin
                for (i = 0; i < 5; i = i + 1) ureg[i] <= 16'h0000 - sense[i];
                cmd_pend[`ICL_CMD_AUTONULL] <= 1'b0;
                cmd_pend[`ICL_CMD_FLASH]    <= 1'b1;
            end else if (cmd_pend[`ICL_CMD_DAC_LATCH]) begin
                o_dac_level <= ureg[`ICL_IDX_AUX_DAC][11:0];
                cmd_pend[`ICL_CMD_DAC_LATCH] <= 1'b0;
            end else if (cmd_pend[`ICL_CMD_FLASH]) begin
                // An unread flash error locks the store until status is read or the clear command runs
                if (flash_err) begin
                    cmd_pend[`ICL_CMD_FLASH] <= 1'b0;
                end else begin
                    flash_cnt <= 24'h000000;
                    state     <= ST_FLASH;
                end
            end
        end
    end

    assign o_x_accel_offset        = ureg[`ICL_IDX_X_ACCEL];
    assign o_y_accel_offset        = ureg[`ICL_IDX_Y_ACCEL];
    assign o_x_tilt_offset         = ureg[`ICL_IDX_X_TILT];
    assign o_y_tilt_offset         = ureg[`ICL_IDX_Y_TILT];
    assign o_vertical_angle_offset = ureg[`ICL_IDX_VERT];

    // Two alarms
    wire [15:0] alarm_control = ureg[`ICL_IDX_ALARM_CONTROL];
    wire [1:0]  alm_set;
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_alm
            wire [2:0]  src  = alarm_control[`ICL_ALM_SRC_LSB + 4*k +: 3];
            wire        angl = (src == `ICL_SRC_X_TILT) || (src == `ICL_SRC_Y_TILT) ||
                               (src == `ICL_SRC_VERT);
            wire        filt_on = alarm_control[`ICL_ALM_FILT_BIT + 4*k] | angl;
            wire        rate = alarm_control[`ICL_ALM_RATE_BIT + k];
            wire [15:0] mag  = ureg[`ICL_IDX_ALM_THR1 + k];
            wire [7:0]  nds  = ureg[`ICL_IDX_ALM_SMPL1 + k][7:0];
            wire [7:0]  last = (nds == 8'h00) ? 8'h00 : nds - 8'h01;
            reg  [15:0] raw;
            reg  signed [15:0] filt;
            reg  signed [15:0] prev;
            reg  signed [24:0] acc;
            reg  [7:0]  cnt;
            reg         hit;
            always @* begin
                case (src)
                    `ICL_SRC_X_ACCEL: raw = i_x_accel_result;
                    `ICL_SRC_Y_ACCEL: raw = i_y_accel_result;
                    `ICL_SRC_X_TILT:  raw = i_x_tilt_result;
                    `ICL_SRC_Y_TILT:  raw = i_y_tilt_result;
                    `ICL_SRC_VERT:    raw = i_vertical_angle_result;
                    `ICL_SRC_SUPPLY:  raw = {4'h0, i_supply_result};
                    default:          raw = 16'h0000;
                endcase
            end
            // Recursive half-weight average of the source and the previous filter output stands in as the filtered view of the source
            wire signed [16:0] fsum = $signed({raw[15], raw}) + $signed({filt[15], filt});
            wire signed [15:0] fnew = fsum[16:1];
            wire signed [15:0] val  = filt_on ? fnew : $signed(raw);
            wire signed [15:0] thr  = {mag[14], mag[14:0]};
            wire signed [24:0] dif  = $signed({{9{val[15]}}, val}) - $signed({{9{prev[15]}}, prev});
            wire signed [24:0] acn  = acc + dif;
            // Sum compared with threshold times count avoids a divider
            wire signed [24:0] lim  = thr * $signed({1'b0, (nds == 8'h00) ? 8'h01 : nds});
            wire signed [24:0] cmpv = rate ? acn : $signed({{9{val[15]}}, val});
            wire signed [24:0] cmpt = rate ? lim : $signed({{9{thr[15]}}, thr});
            wire trip = mag[15] ? (cmpv > cmpt) : (cmpv < cmpt);
            always @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    filt <= 16'h0000; prev <= 16'h0000; acc <= 25'h0000000;
                    cnt <= 8'h00; hit <= 1'b0;
                end else if (i_sample_valid && src != 3'h0) begin
                    filt <= fnew;
                    prev <= val;
                    if (!rate) begin
                        hit <= trip;
                    end else if (cnt >= last) begin
                        hit <= trip;
                        acc <= 25'h0000000;
                        cnt <= 8'h00;
                    end else begin
                        acc <= acn;
                        cnt <= cnt + 8'h01;
                    end
                end else if (src == 3'h0) begin
                    hit <= 1'b0;
                end
            end
            assign alm_set[k] = hit;
        end
    endgenerate

    // Status flags: hardware set wins over any clear in the same cycle
    wire low_now = i_sample_valid && (i_supply_result <= `ICL_LOW_SUPPLY_CODE);
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= 16'h0000; o_alarm <= 2'h0; o_alarm_pin <= 1'b0;
        end else begin
            o_alarm     <= alm_set;
            o_alarm_pin <= ((|alm_set) & alarm_control[`ICL_ALM_OUT_EN_BIT]) ^
                           ~alarm_control[`ICL_ALM_OUT_POL_BIT];
            if (clear_req)
                status <= 16'h0000;
            if (st_read)
                status[`ICL_ST_FLASH_ERR] <= 1'b0;
            if (i_sample_valid && !low_now)
                status[`ICL_ST_LOW_SUPPLY] <= 1'b0;
            if (low_now)
                status[`ICL_ST_LOW_SUPPLY] <= 1'b1;
            if (flash_fail)
                status[`ICL_ST_FLASH_ERR] <= 1'b1;
            if (alm_set[0]) status[`ICL_ST_ALARM1] <= 1'b1;
            if (alm_set[1]) status[`ICL_ST_ALARM1 + 1] <= 1'b1;
        end
    end
endmodule // icl_cmd_alarm_status

// file: pkg/icl_cmd_regs.vh
// Register offsets, field positions, reset values and timing counts of the command block
`ifndef ICL_CMD_REGS_VH
`define ICL_CMD_REGS_VH

// Clock rate and documented times
`define ICL_CLK_HZ          10000000
`define ICL_FLASH_TIME_MS   50
`define ICL_POR_TIME_MS     128
`define ICL_FLASH_CYCLES    (`ICL_FLASH_TIME_MS * (`ICL_CLK_HZ / 1000))
`define ICL_POR_CYCLES      (`ICL_POR_TIME_MS * (`ICL_CLK_HZ / 1000))

// Byte addresses on the serial port (even = low byte, odd = high byte)
`define ICL_ADDR_USER_BASE  7'h20
`define ICL_ADDR_USER_LAST  7'h35
`define ICL_ADDR_STATUS     7'h3c
`define ICL_ADDR_COMMAND    7'h3e

// Word index of each user register counted from the base
`define ICL_IDX_X_ACCEL     4'h0
`define ICL_IDX_Y_ACCEL     4'h1
`define ICL_IDX_X_TILT      4'h2
`define ICL_IDX_Y_TILT      4'h3
`define ICL_IDX_VERT        4'h4
`define ICL_IDX_ALARM_CONTROL    4'h5
`define ICL_IDX_ALM_THR1    4'h6
`define ICL_IDX_ALM_SMPL1   4'h8
`define ICL_IDX_AUX_DAC     4'ha
`define ICL_NUM_USER        11
`define ICL_NUM_FLASH       10

// Reset / factory default values
`define ICL_OFFSET_DEFAULT  16'h0000
`define ICL_USER_RESET      16'h0000

// Command register bits
`define ICL_CMD_AUTONULL    0
`define ICL_CMD_FACTORY     1
`define ICL_CMD_DAC_LATCH   2
`define ICL_CMD_FLASH       3
`define ICL_CMD_CLEAR       4
`define ICL_CMD_SWRESET     7
`define ICL_CMD_MASK        8'h9f

// Status register bits
`define ICL_ST_LOW_SUPPLY   0
`define ICL_ST_FLASH_ERR    2
`define ICL_ST_ALARM1       8

// Alarm control fields (alarm k adds 4*k to source/filter, k to rate; output enable and polarity are shared)
`define ICL_ALM_SRC_LSB     0
`define ICL_ALM_FILT_BIT    3
`define ICL_ALM_RATE_BIT    8
`define ICL_ALM_OUT_EN_BIT  10
`define ICL_ALM_OUT_POL_BIT 11

// Alarm sources
`define ICL_SRC_X_ACCEL     3'h1
`define ICL_SRC_Y_ACCEL     3'h2
`define ICL_SRC_X_TILT      3'h3
`define ICL_SRC_Y_TILT      3'h4
`define ICL_SRC_VERT        3'h5
`define ICL_SRC_SUPPLY      3'h6

// Supply code at the low-voltage threshold
`define ICL_LOW_SUPPLY_CODE 12'h4a6

`endif

// file: tb/icl_cmd_alarm_status_sva.sv
// Port-level assertions for the command, offset, alarm and status block
`timescale 1ns/1ps
module icl_cmd_alarm_status_sva #(
    parameter FLASH_CYCLES = 20,
    parameter POR_CYCLES   = 50
) (
    // Clock and reset
    input wire        i_ref_clk,
    input wire        i_rst_n,
    // Watched inputs
    input wire        i_spi_cs_n,
    input wire        i_vdd_above_high,
    // Watched outputs
    input wire        o_spi_miso_oe,
    input wire [11:0] o_dac_level,
    input wire        o_core_restart,
    input wire        o_por_reset,
    input wire        o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    reg [31:0] busy_run;
    reg [31:0] low_run;
    // Run lengths kept in counters so long waits need no repetition operator
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_run <= 32'h0;
            low_run  <= 32'h0;
        end else begin
            busy_run <= o_busy ? busy_run + 32'h1 : 32'h0;
            low_run  <= i_vdd_above_high ? 32'h0 : low_run + 32'h1;
        end
    end
    property p_oe_on;
        $fell(i_spi_cs_n) |-> ##[1:3] o_spi_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso enable late after select");
    property p_oe_off;
        $rose(i_spi_cs_n) |-> ##[1:3] !o_spi_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso enable held after deselect");
    property p_busy_bound;
        busy_run <= FLASH_CYCLES + 8;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy longer than a flash write");
    property p_dac_hold;
        $changed(o_dac_level) |-> $past(o_busy || o_core_restart) || $past(o_core_restart, 2);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("dac level moved without a command");
    property p_restart_pulse;
        o_core_restart |=> !o_core_restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart wider than one cycle");
    property p_restart_cause;
        $rose(o_core_restart) |-> $past(o_busy) || $past(o_por_reset);
    endproperty
    a_restart_cause: assert property (p_restart_cause) else $error("restart without a cause");
    property p_por_restart;
        o_por_reset |=> o_core_restart && !o_por_reset;
    endproperty
    a_por_restart: assert property (p_por_restart) else $error("power-on reset pulse malformed");
    property p_por_wait;
        o_por_reset |-> low_run >= POR_CYCLES;
    endproperty
    a_por_wait: assert property (p_por_wait) else $error("power-on reset before timeout");
endmodule // icl_cmd_alarm_status_sva

bind icl_cmd_alarm_status icl_cmd_alarm_status_sva #(
    .FLASH_CYCLES(FLASH_CYCLES),
    .POR_CYCLES(POR_CYCLES)
) u_sva (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n),
    .i_vdd_above_high(i_vdd_above_high), .o_spi_miso_oe(o_spi_miso_oe),
    .o_dac_level(o_dac_level), .o_core_restart(o_core_restart),
    .o_por_reset(o_por_reset), .o_busy(o_busy)
);

// file: tb/icl_spi_host.sv
// Host processor model: serial master, mode 3, 800 ns bit period
`timescale 1ns/1ps
module icl_spi_host (
    // Clock
    input  wire i_clk,
    // Serial lines
    output reg  o_sclk,
    output reg  o_cs_n,
    output reg  o_mosi,
    input  wire i_miso
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end
    // Four reference clocks per half bit keeps above the three-clock minimum
    task half;
        begin
            repeat (4) @(posedge i_clk);
            #1;
        end
    endtask
    // One 16-bit frame; the previous request's answer comes back in r
    task xfer(input [15:0] w, output [15:0] r);
        integer k;
        begin
            r = 16'h0;
            o_cs_n = 1'b0;
            half;
            for (k = 15; k >= 0; k = k - 1) begin
                o_sclk = 1'b0;
                o_mosi = w[k];
                half;
                r = {r[14:0], i_miso};
                o_sclk = 1'b1;
                half;
            end
            o_cs_n = 1'b1;
            // Released data line shows no stale value
            o_mosi = ~o_mosi;
            half;
        end
    endtask
endmodule // icl_spi_host

// file: tb/icl_cmd_alarm_status_test.sv
// Self-checking bench for the command, offset, alarm and status block
`timescale 1ns/1ps
module icl_cmd_alarm_status_test;
    localparam F = 20;
    localparam P = 50;
    reg         clk = 1'b0, rst_n = 1'b0, sv = 1'b0, ff = 1'b0, vhi = 1'b1, vlo = 1'b1;
    reg  [15:0] xa = 16'h0, ya = 16'h0, xt = 16'h0, yt = 16'h0, va = 16'h0;
    reg  [11:0] sup = 12'h800;
    reg  [15:0] r, v;
    wire        sclk, cs_n, mosi, miso, oe, rst_p, por, busy, pin;
    wire [15:0] ox, oy, otx, oty, ov;
    wire [11:0] dac;
    wire [1:0]  alm;
    integer     err_total = 0, total_checks = 0, cyc = 0, run = 0, last_run = 0, por_seen = 0;

    always #50 clk = ~clk;

    icl_cmd_alarm_status #(.FLASH_CYCLES(F), .POR_CYCLES(P)) uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_sample_valid(sv),
        .i_x_accel_result(xa), .i_y_accel_result(ya), .i_x_tilt_result(xt),
        .i_y_tilt_result(yt), .i_vertical_angle_result(va), .i_supply_result(sup),
        .i_flash_fault(ff), .i_vdd_above_low(vlo), .i_vdd_above_high(vhi),
        .o_x_accel_offset(ox), .o_y_accel_offset(oy), .o_x_tilt_offset(otx),
        .o_y_tilt_offset(oty), .o_vertical_angle_offset(ov), .o_dac_level(dac),
        .o_alarm(alm), .o_alarm_pin(pin), .o_core_restart(rst_p), .o_por_reset(por),
        .o_busy(busy)
    );
    icl_spi_host host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

    // Busy run lengths, power-on pulses and the hang limit
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (busy === 1'b1) begin
            run = run + 1;
        end else if (run != 0) begin
            last_run = run;
            run = 0;
        end
        if (por === 1'b1) por_seen = 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end

    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [63:0] name, input [15:0] e, input [15:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("[ERR] %0s expected %h seen %h", name, e, g);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wr(input [6:0] a, input [7:0] d); host.xfer({1'b1, a, d}, r); endtask
    task wr16(input [6:0] a, input [15:0] d);
        begin
            wr(a, d[7:0]);
            wr(a + 7'h1, d[15:8]);
        end
    endtask
    // Answer arrives in the following frame, a harmless command read
    task rd(input [6:0] a, output [15:0] d);
        begin
            host.xfer({1'b0, a, 8'h00}, r);
            host.xfer(16'h3e00, d);
        end
    endtask
    task idle;
        integer n;
        begin
            n = 0;
            while (busy !== 1'b0 && n < 200) begin
                tick(1);
                n = n + 1;
            end
            tick(1);
        end
    endtask
    // Host writes only the command low byte, then waits for completion
    task cmd(input [7:0] c);
        begin
            wr(7'h3e, c);
            idle;
        end
    endtask
    task smp(input [15:0] x, input [11:0] s);
        begin
            xa = x;
            sup = s;
            sv = 1'b1;
            tick(1);
            sv = 1'b0;
            tick(6);
        end
    endtask
    task sts(input [15:0] e);
        begin
            rd(7'h3c, v);
            chk("status", e, v);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        tick(4);
        chk("dac", 16'h0, {4'h0, dac});
        chk("xoff", 16'h0, ox);
        rd(7'h3e, v);
        chk("command", 16'h0, v);
        $display("test reset done");
        wr(7'h34, 8'hbc);
        wr(7'h35, 8'h0a);
        chk("dac", 16'h0, {4'h0, dac});
        cmd(8'h04);
        chk("dac", 16'h0abc, {4'h0, dac});
        wr(7'h34, 8'h11);
        chk("dac", 16'h0abc, {4'h0, dac});
        $display("test dac done");
        wr16(7'h20, 16'h1234);
        chk("xoff", 16'h1234, ox);
        ya = 16'hfff0;
        xt = 16'h0020;
        yt = 16'h8001;
        va = 16'h0005;
        smp(16'h0100, 12'h800);
        // Factory runs before autonull; all five offsets, vertical angle included, are checked
        cmd(8'h03);
        chk("xoff", 16'hff00, ox);
        chk("yoff", 16'h0010, oy);
        chk("xtoff", 16'hffe0, otx);
        chk("ytoff", 16'h7fff, oty);
        chk("voff", 16'hfffb, ov);
        chk("flash", 16'h1, {15'h0, last_run >= F + 1 && last_run <= F + 4});
        sts(16'h0000);
        cmd(8'h02);
        chk("xoff", 16'h0, ox);
        chk("voff", 16'h0, ov);
        cmd(8'h80);
        chk("xoff", 16'hff00, ox);
        chk("ytoff", 16'h7fff, oty);
        $display("test offsets done");
        ff = 1'b1;
        cmd(8'h08);
        chk("flash", 16'h1, {15'h0, last_run >= F + 1 && last_run <= F + 3});
        ff = 1'b0;
        cmd(8'h08);
        chk("blocked", 16'h1, {15'h0, last_run < F});
        sts(16'h0004);
        sts(16'h0000);
        $display("test flash done");
        smp(16'h0, 12'h4a6);
        sts(16'h0001);
        host.xfer(16'hbe10, r);
        idle;
        sts(16'h0000);
        smp(16'h0, 12'h4a6);
        smp(16'h0, 12'h4a7);
        sts(16'h0000);
        $display("test status done");
        wr16(7'h2c, 16'h8100);
        wr16(7'h2e, 16'h0300);
        wr16(7'h2a, 16'h0411);
        smp(16'h0200, 12'h800);
        chk("alarm", 16'h3, {14'h0, alm});
        chk("pin", 16'h0, {15'h0, pin});
        smp(16'h0000, 12'h800);
        chk("alarm", 16'h2, {14'h0, alm});
        smp(16'h0400, 12'h800);
        chk("alarm", 16'h1, {14'h0, alm});
        sts(16'h0300);
        $display("test alarm done");
        // Rate mode, two samples: mean step 0x20 trips above 0x10, mean step 4 does not
        wr16(7'h30, 16'h0002);
        wr16(7'h2c, 16'h8010);
        wr16(7'h2a, 16'h0101);
        smp(16'h0400, 12'h800);
        smp(16'h0440, 12'h800);
        chk("rate", 16'h1, {14'h0, alm});
        smp(16'h0440, 12'h800);
        smp(16'h0448, 12'h800);
        chk("rate", 16'h0, {14'h0, alm});
        $display("test rate done");
        // Supply below the lower level: window timer must not run
        vhi = 1'b0;
        vlo = 1'b0;
        por_seen = 0;
        tick(P + 10);
        chk("por", 16'h0, por_seen[15:0]);
        // Supply parked between the two comparator levels
        vlo = 1'b1;
        tick(P + 10);
        chk("por", 16'h1, por_seen[15:0]);
        vhi = 1'b1;
        $display("test power-on done");
        end_of_test;
    end
endmodule // icl_cmd_alarm_status_test
